// *** sdem_pkg.sv ***
// Shared constants, types and carriers of the servo deviation error monitor.
// Assumes a single 40 MHz clock domain and a synchronous active-low reset.
package sdem_pkg;

   localparam int POS_W = 32;
   localparam int SPD_W = 16;
   localparam int TRQ_W = 16;
   localparam int LIM_W = 16;
   localparam int VAL_W = 16;
   localparam int SEL_W = 4;

   // Weights inside the check selection digit
   localparam int SEL_POS_BIT = 0;
   localparam int SEL_SPD_BIT = 1;
   localparam int SEL_TRQ_BIT = 2;
   localparam logic [SEL_W-1:0] SEL_RESET = 4'h3;
   localparam logic [SEL_W-1:0] SEL_MAX   = 4'h7;

   // Limits: position in 0.01 rev, speed in r/min, torque in percent of rating
   localparam logic [LIM_W-1:0] POS_LIM_RESET = 16'h0009;
   localparam logic [LIM_W-1:0] POS_LIM_MIN   = 16'h0001;
   localparam logic [LIM_W-1:0] POS_LIM_MAX   = 16'h03E8;
   localparam logic [LIM_W-1:0] SPD_LIM_RESET = 16'h0064;
   localparam logic [LIM_W-1:0] SPD_LIM_MIN   = 16'h0001;
   localparam logic [LIM_W-1:0] SPD_LIM_MAX   = 16'h07D0;
   localparam logic [LIM_W-1:0] TRQ_LIM_RESET = 16'h0064;
   localparam logic [LIM_W-1:0] TRQ_LIM_MIN   = 16'h0001;
   localparam logic [LIM_W-1:0] TRQ_LIM_MAX   = 16'h03E8;

   // Pole detection selection: lowest digit 1 asks for detection at first servo-on
   localparam logic [VAL_W-1:0] POLE_SEL_RESET = 16'h0301;
   localparam int               POLE_DIGIT_LSB = 0;
   localparam logic [3:0]       POLE_DIGIT_ON  = 4'h1;

   typedef enum logic [2:0] {
      SDEM_PARAM_SELECT = 3'b000,
      SDEM_PARAM_POS    = 3'b001,
      SDEM_PARAM_SPD    = 3'b010,
      SDEM_PARAM_TRQ    = 3'b011,
      SDEM_PARAM_POLE   = 3'b100
   } sdem_param_t;

   // Alarm codes: 42.1 position, 42.2 speed, 42.3 torque
   typedef enum logic [1:0] {
      SDEM_ALARM_NONE = 2'b00,
      SDEM_ALARM_POS  = 2'b01,
      SDEM_ALARM_SPD  = 2'b10,
      SDEM_ALARM_TRQ  = 2'b11
   } sdem_alarm_t;

   typedef struct packed {
      sdem_param_t      id;
      logic [VAL_W-1:0] value;
   } sdem_param_wr_t;

   typedef struct packed {
      logic signed [POS_W-1:0] model_pos;
      logic signed [POS_W-1:0] fb_pos;
      logic signed [SPD_W-1:0] model_spd;
      logic signed [SPD_W-1:0] fb_spd;
      logic signed [TRQ_W-1:0] cmd_trq;
      logic signed [TRQ_W-1:0] fb_trq;
   } sdem_sample_t;

endpackage : sdem_pkg

// *** sdem_cmp.sv ***
// One deviation comparison: flags when |a - b| exceeds the limit.
// Assumes the caller holds a and b stable in the strobe cycle.
module sdem_cmp
   import sdem_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                strobe,
   input  wire logic                enable,
   input  wire logic signed [W-1:0] a,
   input  wire logic signed [W-1:0] b,
   input  wire logic [LIM_W-1:0]    limit,
   output logic                     over
);

   logic signed [W:0] diff;
   logic        [W:0] mag;
   logic        [W:0] lim_ext;

   // One extra bit so that the difference of two extremes cannot wrap
   always_comb begin
      diff    = {a[W-1], a} - {b[W-1], b};
      mag     = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
      lim_ext = (W+1)'(limit);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         over <= 1'b0;
      end else begin
         over <= strobe && enable && (mag > lim_ext);
      end
   end

endmodule : sdem_cmp

// *** sdem_pole.sv ***
// Servo-on sequencer with magnetic pole detection after each power-on.
// Assumes the pole detection engine answers a held start with a done pulse.
module sdem_pole
   import sdem_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic power_cycle,
   input  wire logic need_detect,
   input  wire logic servo_on_req,
   input  wire logic pole_done,
   input  wire logic force_off,
   output logic      pole_busy,
   output logic      servo_on_status
);

   typedef enum logic [1:0] {
      SDEM_POLE_OFF    = 2'b00,
      SDEM_POLE_DETECT = 2'b01,
      SDEM_POLE_ON     = 2'b10
   } sdem_pole_state_t;

   sdem_pole_state_t state_reg;
   sdem_pole_state_t state_next;
   logic             armed_reg;

   // Detection is owed once per power-on, consumed when it completes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         armed_reg <= 1'b1;
      end else if (power_cycle) begin
         armed_reg <= 1'b1;
      end else if (state_reg == SDEM_POLE_DETECT && pole_done) begin
         armed_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SDEM_POLE_OFF: begin
            if (servo_on_req && !force_off) begin
               state_next = (armed_reg && need_detect) ? SDEM_POLE_DETECT : SDEM_POLE_ON;
            end
         end
         SDEM_POLE_DETECT: begin
            if (!servo_on_req || force_off) begin
               state_next = SDEM_POLE_OFF;
            end else if (pole_done) begin
               state_next = SDEM_POLE_ON;
            end
         end
         SDEM_POLE_ON: begin
            if (!servo_on_req || force_off) begin
               state_next = SDEM_POLE_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n || power_cycle) begin
         state_reg <= SDEM_POLE_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pole_busy       = (state_reg == SDEM_POLE_DETECT);
   assign servo_on_status = (state_reg == SDEM_POLE_ON);

endmodule : sdem_pole

// *** sdem_top.sv ***
// Servo deviation error monitor: three programmable deviation checks that
// latch a servo control error and stop the motor, plus the servo-on sequence.
// Assumes all inputs come from logic on the same 40 MHz clock; the
// controller writes parameters one per cycle through param_wr_valid.
//
// Contract
// - Selection weight 1 enables position check
// - Selection weight 2 enables speed check
// - Selection weight 4 enables torque check
// - Combined selection values enable several checks
// - Selection defaults to 3 after initialisation
// - Position deviation over limit raises 42.1, stops
// - Position limit starts at 0.09 rev
// - Speed deviation over limit raises 42.2, stops
// - Speed limit starts at 100 r/min
// - Torque deviation over limit raises 42.3, stops
// - Torque limit starts at 100 percent
// - New selection applies after power cycle or reset
// - Power-cycle parameters apply only after power cycle
// - Incremental: pole detection at first servo-on
module sdem_top
   import sdem_pkg::*;
(
   input  wire logic           clock,
   input  wire logic           rst_n,
   input  wire logic           power_cycle,
   input  wire logic           ctrl_reset,
   input  wire logic           param_wr_valid,
   input  wire sdem_param_wr_t param_wr,
   input  wire logic           abs_system,
   input  wire logic           servo_on_req,
   input  wire logic           pole_done,
   input  wire logic           cycle_strobe,
   input  wire sdem_sample_t   sample,
   input  wire logic           alarm_clear,
   input  wire logic           pos_cmd_valid,
   output logic                param_wr_error,
   output logic                restart_pending,
   output logic [SEL_W-1:0]    deviation_check_select,
   output logic [LIM_W-1:0]    position_error_limit,
   output logic [LIM_W-1:0]    speed_error_limit,
   output logic [LIM_W-1:0]    torque_error_limit,
   output logic [VAL_W-1:0]    pole_detect_function_select,
   output logic                pole_detect_busy,
   output logic                servo_on_status,
   output logic                ready,
   output logic                pos_cmd_accept,
   output logic                pos_cmd_reject,
   output sdem_alarm_t         alarm_code,
   output logic                alarm_active,
   output logic                motor_stop
);

   // Stored (written) values and the copies that steer the logic
   logic [SEL_W-1:0] sel_store_reg;
   logic [SEL_W-1:0] sel_active_reg;
   logic [VAL_W-1:0] pole_store_reg;
   logic [VAL_W-1:0] pole_active_reg;
   logic [LIM_W-1:0] pos_lim_reg;
   logic [LIM_W-1:0] spd_lim_reg;
   logic [LIM_W-1:0] trq_lim_reg;
   logic             abs_reg;
   logic             restart_seen_reg;

   logic             wr_ok;
   logic             en_pos;
   logic             en_spd;
   logic             en_trq;
   logic             over_pos;
   logic             over_spd;
   logic             over_trq;
   logic             hit;
   sdem_alarm_t      hit_code;
   sdem_alarm_t      alarm_reg;
   logic             err_reg;
   logic             accept_reg;
   logic             reject_reg;
   logic             need_detect;

   // Range check of a parameter write; out-of-range values are refused whole
   always_comb begin
      wr_ok = 1'b0;
      unique case (param_wr.id)
         SDEM_PARAM_SELECT: begin
            wr_ok = (param_wr.value <= VAL_W'(SEL_MAX));
         end
         SDEM_PARAM_POS: begin
            wr_ok = (param_wr.value >= POS_LIM_MIN) && (param_wr.value <= POS_LIM_MAX);
         end
         SDEM_PARAM_SPD: begin
            wr_ok = (param_wr.value >= SPD_LIM_MIN) && (param_wr.value <= SPD_LIM_MAX);
         end
         SDEM_PARAM_TRQ: begin
            wr_ok = (param_wr.value >= TRQ_LIM_MIN) && (param_wr.value <= TRQ_LIM_MAX);
         end
         SDEM_PARAM_POLE: begin
            wr_ok = 1'b1;
         end
         default: begin
            wr_ok = 1'b0;
         end
      endcase
   end

   // Refusal is a one-cycle pulse after the write
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         err_reg <= 1'b0;
      end else begin
         err_reg <= param_wr_valid && !wr_ok;
      end
   end

   // Limits carry no restart requirement and take effect on the next cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pos_lim_reg <= POS_LIM_RESET;
         spd_lim_reg <= SPD_LIM_RESET;
         trq_lim_reg <= TRQ_LIM_RESET;
      end else if (param_wr_valid && wr_ok) begin
         if (param_wr.id == SDEM_PARAM_POS) begin
            pos_lim_reg <= param_wr.value;
         end
         if (param_wr.id == SDEM_PARAM_SPD) begin
            spd_lim_reg <= param_wr.value;
         end
         if (param_wr.id == SDEM_PARAM_TRQ) begin
            trq_lim_reg <= param_wr.value;
         end
      end
   end

   // Written selection values wait in the store until a restart event
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel_store_reg  <= SEL_RESET;
         pole_store_reg <= POLE_SEL_RESET;
      end else if (param_wr_valid && wr_ok) begin
         if (param_wr.id == SDEM_PARAM_SELECT) begin
            sel_store_reg <= param_wr.value[SEL_W-1:0];
         end
         if (param_wr.id == SDEM_PARAM_POLE) begin
            pole_store_reg <= param_wr.value;
         end
      end
   end

   // A write in the same cycle as the restart is not taken by that restart
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel_active_reg <= SEL_RESET;
      end else if (power_cycle || ctrl_reset) begin
         sel_active_reg <= sel_store_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pole_active_reg <= POLE_SEL_RESET;
      end else if (power_cycle) begin
         pole_active_reg <= pole_store_reg;
      end
   end

   // Position system kind is sampled at reset release and at each power cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         abs_reg <= 1'b0;
      end else if (power_cycle || !restart_seen_reg) begin
         abs_reg <= abs_system;
      end
   end

   // Marks the first cycle after reset release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         restart_seen_reg <= 1'b0;
      end else begin
         restart_seen_reg <= 1'b1;
      end
   end

   // Incremental systems detect every power-on; absolute ones only on request
   assign need_detect = !abs_reg
                        || (pole_active_reg[POLE_DIGIT_LSB +: 4] == POLE_DIGIT_ON);

   // Enables follow the applied copy, not the store
   always_comb begin
      en_pos = sel_active_reg[SEL_POS_BIT];
      en_spd = sel_active_reg[SEL_SPD_BIT];
      en_trq = sel_active_reg[SEL_TRQ_BIT];
   end

   // Each enabled check runs independently, so any combination works; a zero
   // selection leaves all three disabled
   sdem_cmp #(
      .W (POS_W)
   ) u_cmp_pos (
      .clock  (clock),
      .rst_n  (rst_n),
      .strobe (cycle_strobe && servo_on_status),
      .enable (en_pos),
      .a      (sample.model_pos),
      .b      (sample.fb_pos),
      .limit  (pos_lim_reg),
      .over   (over_pos)
   );

   sdem_cmp #(
      .W (SPD_W)
   ) u_cmp_spd (
      .clock  (clock),
      .rst_n  (rst_n),
      .strobe (cycle_strobe && servo_on_status),
      .enable (en_spd),
      .a      (sample.model_spd),
      .b      (sample.fb_spd),
      .limit  (spd_lim_reg),
      .over   (over_spd)
   );

   sdem_cmp #(
      .W (TRQ_W)
   ) u_cmp_trq (
      .clock  (clock),
      .rst_n  (rst_n),
      .strobe (cycle_strobe && servo_on_status),
      .enable (en_trq),
      .a      (sample.cmd_trq),
      .b      (sample.fb_trq),
      .limit  (trq_lim_reg),
      .over   (over_trq)
   );

   // Simultaneous trips report position first, then speed, then torque
   always_comb begin
      hit      = over_pos || over_spd || over_trq;
      hit_code = SDEM_ALARM_NONE;
      if (over_pos) begin
         hit_code = SDEM_ALARM_POS;
      end else if (over_spd) begin
         hit_code = SDEM_ALARM_SPD;
      end else if (over_trq) begin
         hit_code = SDEM_ALARM_TRQ;
      end
   end

   // First alarm holds; a trip in the clearing cycle wins over the clear
   always_ff @(posedge clock) begin
      if (!rst_n || power_cycle) begin
         alarm_reg <= SDEM_ALARM_NONE;
      end else if (alarm_reg == SDEM_ALARM_NONE || alarm_clear || ctrl_reset) begin
         alarm_reg <= hit ? hit_code : SDEM_ALARM_NONE;
      end
   end

   // A trip drops the servo at the edge its alarm latches
   sdem_pole u_pole (
      .clock           (clock),
      .rst_n           (rst_n),
      .power_cycle     (power_cycle),
      .need_detect     (need_detect),
      .servo_on_req    (servo_on_req),
      .pole_done       (pole_done),
      .force_off       (alarm_active || hit),
      .pole_busy       (pole_detect_busy),
      .servo_on_status (servo_on_status)
   );

   // Commands before ready are refused rather than trusted to the controller
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         accept_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         accept_reg <= pos_cmd_valid && ready;
         reject_reg <= pos_cmd_valid && !ready;
      end
   end

   assign ready                       = servo_on_status && !alarm_active;
   assign alarm_active                = (alarm_reg != SDEM_ALARM_NONE);
   assign alarm_code                  = alarm_reg;
   assign motor_stop                  = alarm_active;
   assign param_wr_error              = err_reg;
   assign pos_cmd_accept              = accept_reg;
   assign pos_cmd_reject              = reject_reg;
   assign deviation_check_select      = sel_active_reg;
   assign pole_detect_function_select = pole_active_reg;
   assign position_error_limit        = pos_lim_reg;
   assign speed_error_limit           = spd_lim_reg;
   assign torque_error_limit          = trq_lim_reg;
   assign restart_pending             = (sel_store_reg != sel_active_reg)
                                        || (pole_store_reg != pole_active_reg);

endmodule : sdem_top

// *** sdem_top_assertions.sv ***
// Port-level checker for the deviation monitor.
// Assumes it is bound to sdem_top; one clock, synchronous active-low reset.
module sdem_top_assertions
   import sdem_pkg::*;
(
   input wire logic               clock,
   input wire logic               rst_n,
   input wire logic               power_cycle,
   input wire logic               ctrl_reset,
   input wire logic               param_wr_valid,
   input wire sdem_param_wr_t     param_wr,
   input wire logic               cycle_strobe,
   input wire logic               alarm_clear,
   input wire logic               pos_cmd_valid,
   input wire logic               param_wr_error,
   input wire logic [SEL_W-1:0]   deviation_check_select,
   input wire logic [LIM_W-1:0]   position_error_limit,
   input wire logic               servo_on_status,
   input wire logic               ready,
   input wire logic               pos_cmd_accept,
   input wire logic               pos_cmd_reject,
   input wire sdem_alarm_t        alarm_code,
   input wire logic               alarm_active,
   input wire logic               motor_stop
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_raise;
      !alarm_active ##1 alarm_active;
   endsequence
   sequence s_quiet_cfg;
      !ctrl_reset && !power_cycle ##1 !ctrl_reset && !power_cycle;
   endsequence

   a_stop_on_alarm: assert property (motor_stop == alarm_active
      && !(alarm_active && servo_on_status))
      else $error("motor stop differs from alarm state");
   a_ready_decode: assert property (ready == (servo_on_status && !alarm_active))
      else $error("ready does not reflect servo on without alarm");
   a_cmd_accept: assert property (pos_cmd_valid && ready |=> pos_cmd_accept && !pos_cmd_reject)
      else $error("command while ready not accepted");
   a_cmd_reject: assert property (pos_cmd_valid && !ready |=> pos_cmd_reject && !pos_cmd_accept)
      else $error("command while not ready not rejected");
   a_alarm_latched: assert property (alarm_active && !alarm_clear && !ctrl_reset
      && !power_cycle |=> alarm_active && $stable(alarm_code))
      else $error("alarm left its latch");
   a_alarm_cause: assert property ($rose(alarm_active) |-> $past(cycle_strobe, 2))
      else $error("alarm raised without a strobe two cycles before");
   a_servo_drops: assert property (s_raise |=> !servo_on_status)
      else $error("servo stayed on after alarm");
   a_pos_limit_wr: assert property (param_wr_valid && param_wr.id == SDEM_PARAM_POS
      && param_wr.value >= POS_LIM_MIN && param_wr.value <= POS_LIM_MAX
      |=> position_error_limit == $past(param_wr.value))
      else $error("position limit write not taken");
   a_sel_refused: assert property (param_wr_valid && param_wr.id == SDEM_PARAM_SELECT
      && param_wr.value > 16'h0007 |=> param_wr_error)
      else $error("oversized selection not refused");
   a_sel_held: assert property (s_quiet_cfg |=> $stable(deviation_check_select))
      else $error("selection changed without reset or power cycle");
endmodule : sdem_top_assertions

// *** sdem_ctrl_model.sv ***
// Controller-side partner: answers pole detection and issues positioning commands.
// Assumes go is a one-cycle pulse; early skips the ready interlock only on request.
module sdem_ctrl_model
   import sdem_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       pole_detect_busy,
   input  wire logic       ready,
   input  wire logic       go,
   input  wire logic       early,
   input  wire logic [3:0] pole_delay,
   output logic            pole_done,
   output logic            pos_cmd_valid
);
   logic [3:0] wait_reg;

   // Done is a single pulse; the counter restarts when busy falls
   always_ff @(posedge clock) begin
      if (!rst_n || !pole_detect_busy || pole_done) begin
         wait_reg  <= 4'h0;
         pole_done <= 1'b0;
      end else begin
         wait_reg  <= wait_reg + 4'h1;
         pole_done <= (wait_reg == pole_delay);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pos_cmd_valid <= 1'b0;
      end else begin
         pos_cmd_valid <= go && (ready || early);
      end
   end
endmodule : sdem_ctrl_model

// *** sdem_top_tb.sv ***
// Self-checking bench for the deviation monitor with a controller partner.
// Assumes a 40 MHz clock; all stimulus moves just after rising edges.
module sdem_top_tb
   import sdem_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock, rst_n, power_cycle, ctrl_reset, param_wr_valid, abs_system, servo_on_req;
   logic pole_done, cycle_strobe, alarm_clear, pos_cmd_valid, go, early;
   logic param_wr_error, restart_pending, pole_detect_busy, servo_on_status, ready;
   logic pos_cmd_accept, pos_cmd_reject, alarm_active, motor_stop;
   logic [3:0]       pole_delay;
   logic [SEL_W-1:0] deviation_check_select;
   logic [LIM_W-1:0] position_error_limit, speed_error_limit, torque_error_limit;
   logic [VAL_W-1:0] pole_detect_function_select;
   sdem_param_wr_t   param_wr;
   sdem_sample_t     sample;
   sdem_alarm_t      alarm_code;
   int               n_fail = 0;
   int               samples_checked = 0;

   sdem_top i_dut (.clock, .rst_n, .power_cycle, .ctrl_reset, .param_wr_valid, .param_wr,
      .abs_system, .servo_on_req, .pole_done, .cycle_strobe, .sample, .alarm_clear,
      .pos_cmd_valid, .param_wr_error, .restart_pending, .deviation_check_select,
      .position_error_limit, .speed_error_limit, .torque_error_limit,
      .pole_detect_function_select, .pole_detect_busy, .servo_on_status, .ready,
      .pos_cmd_accept, .pos_cmd_reject, .alarm_code, .alarm_active, .motor_stop);

   sdem_ctrl_model i_ctrl (.clock, .rst_n, .pole_detect_busy, .ready, .go, .early,
      .pole_delay, .pole_done, .pos_cmd_valid);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic wr(input sdem_param_t id, input logic [15:0] v, input logic err);
      @(posedge clock);
      param_wr_valid <= 1'b1;
      param_wr       <= '{id, v};
      @(posedge clock);
      param_wr_valid <= 1'b0;
      @(negedge clock);
      chk("param_wr_error", err, param_wr_error);
   endtask : wr

   task automatic servo_wait(input logic exp_busy);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 40 && servo_on_status !== 1'b1; i++) begin
         @(negedge clock);
         seen |= pole_detect_busy;
      end
      chk("pole_detect_busy", exp_busy, seen);
      if (servo_on_status !== 1'b1) begin
         n_fail++;
         conclude();
      end
   endtask : servo_wait

   task automatic creset();
      @(posedge clock);
      ctrl_reset <= 1'b1;
      @(posedge clock);
      ctrl_reset <= 1'b0;
      repeat (2) @(negedge clock);
   endtask : creset

   task automatic pcycle();
      @(posedge clock);
      power_cycle <= 1'b1;
      @(posedge clock);
      power_cycle <= 1'b0;
      repeat (2) @(negedge clock);
   endtask : pcycle

   task automatic trip(input int dp, input int dsp, input int dt, input sdem_alarm_t exp);
      @(posedge clock);
      sample.model_pos <= dp;
      sample.model_spd <= dsp[15:0];
      sample.cmd_trq   <= dt[15:0];
      cycle_strobe     <= 1'b1;
      @(posedge clock);
      cycle_strobe <= 1'b0;
      repeat (4) @(negedge clock);
      chk("alarm_code", exp, alarm_code);
      chk("motor_stop", exp != SDEM_ALARM_NONE, motor_stop);
      if (exp != SDEM_ALARM_NONE) begin
         @(posedge clock);
         alarm_clear <= 1'b1;
         @(posedge clock);
         alarm_clear <= 1'b0;
         servo_wait(1'b0);
      end
   endtask : trip

   task automatic cmd(input logic erly, input logic exp_acc);
      logic acc;
      logic rej;
      acc = 1'b0;
      rej = 1'b0;
      @(posedge clock);
      early <= erly;
      go    <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (4) begin
         @(negedge clock);
         acc |= pos_cmd_accept;
         rej |= pos_cmd_reject;
      end
      chk("pos_cmd_accept", exp_acc, acc);
      chk("pos_cmd_reject", !exp_acc, rej);
   endtask : cmd

   task automatic t_defaults();
      @(negedge clock);
      chk("deviation_check_select", 3, deviation_check_select);
      chk("position_error_limit", 9, position_error_limit);
      chk("speed_error_limit", 100, speed_error_limit);
      chk("torque_error_limit", 100, torque_error_limit);
      @(posedge clock);
      servo_on_req <= 1'b1;
      servo_wait(1'b1);
      $display("done defaults");
   endtask : t_defaults

   task automatic t_select();
      logic [3:0]  cur;
      logic [3:0]  v;
      sdem_alarm_t e;
      cur = 4'h3;
      for (int i = 0; i < 8; i++) begin
         v = i[3:0];
         wr(SDEM_PARAM_SELECT, {12'h000, v}, 1'b0);
         chk("restart_pending", v != cur, restart_pending);
         chk("deviation_check_select", cur, deviation_check_select);
         creset();
         servo_wait(1'b0);
         chk("deviation_check_select", v, deviation_check_select);
         cur = v;
         e = v[0] ? SDEM_ALARM_POS : v[1] ? SDEM_ALARM_SPD :
             v[2] ? SDEM_ALARM_TRQ : SDEM_ALARM_NONE;
         trip(20, 200, 200, e);
      end
      $display("done select");
   endtask : t_select

   task automatic t_bounds();
      trip(9, 0, 0, SDEM_ALARM_NONE);
      trip(10, 0, 0, SDEM_ALARM_POS);
      trip(0, 100, 0, SDEM_ALARM_NONE);
      trip(0, 101, 0, SDEM_ALARM_SPD);
      trip(0, 0, 100, SDEM_ALARM_NONE);
      trip(0, 0, 101, SDEM_ALARM_TRQ);
      $display("done bounds");
   endtask : t_bounds

   task automatic t_limits();
      wr(SDEM_PARAM_POS, 16'h03E8, 1'b0);
      wr(SDEM_PARAM_POS, 16'h03E9, 1'b1);
      wr(SDEM_PARAM_POS, 16'h0000, 1'b1);
      chk("position_error_limit", 16'h03E8, position_error_limit);
      wr(SDEM_PARAM_SPD, 16'h07D0, 1'b0);
      wr(SDEM_PARAM_SPD, 16'h07D1, 1'b1);
      chk("speed_error_limit", 16'h07D0, speed_error_limit);
      wr(SDEM_PARAM_TRQ, 16'h03E8, 1'b0);
      wr(SDEM_PARAM_TRQ, 16'h0000, 1'b1);
      chk("torque_error_limit", 16'h03E8, torque_error_limit);
      wr(SDEM_PARAM_SELECT, 16'h0008, 1'b1);
      trip(-1000, 0, 0, SDEM_ALARM_NONE);
      trip(-1001, 0, 0, SDEM_ALARM_POS);
      trip(0, -2001, 0, SDEM_ALARM_SPD);
      trip(0, 0, 1001, SDEM_ALARM_TRQ);
      $display("done limits");
   endtask : t_limits

   task automatic t_cmd();
      cmd(1'b0, 1'b1);
      @(posedge clock);
      servo_on_req <= 1'b0;
      repeat (3) @(negedge clock);
      cmd(1'b1, 1'b0);
      @(posedge clock);
      servo_on_req <= 1'b1;
      servo_wait(1'b0);
      $display("done command");
   endtask : t_cmd

   task automatic t_power();
      wr(SDEM_PARAM_SELECT, 16'h0005, 1'b0);
      wr(SDEM_PARAM_POLE, 16'h0300, 1'b0);
      creset();
      chk("deviation_check_select", 5, deviation_check_select);
      chk("pole_detect_function_select", 16'h0301, pole_detect_function_select);
      @(posedge clock);
      servo_on_req <= 1'b0;
      abs_system   <= 1'b1;
      pcycle();
      chk("pole_detect_function_select", 16'h0300, pole_detect_function_select);
      @(posedge clock);
      servo_on_req <= 1'b1;
      servo_wait(1'b0);
      @(posedge clock);
      servo_on_req <= 1'b0;
      abs_system   <= 1'b0;
      pole_delay   <= 4'h0;
      pcycle();
      @(posedge clock);
      servo_on_req <= 1'b1;
      servo_wait(1'b1);
      @(posedge clock);
      abs_system <= 1'b1;
      wr(SDEM_PARAM_POLE, 16'h0301, 1'b0);
      pcycle();
      servo_wait(1'b1);
      $display("done power cycle");
   endtask : t_power

   initial begin
      rst_n          = 1'b0;
      power_cycle    = 1'b0;
      ctrl_reset     = 1'b0;
      param_wr_valid = 1'b0;
      param_wr       = '0;
      abs_system     = 1'b0;
      servo_on_req   = 1'b0;
      cycle_strobe   = 1'b0;
      sample         = '0;
      alarm_clear    = 1'b0;
      go             = 1'b0;
      early          = 1'b0;
      pole_delay     = 4'h5;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_defaults();
      t_select();
      t_bounds();
      t_limits();
      t_cmd();
      t_power();
      conclude();
   end
endmodule : sdem_top_tb

bind sdem_top sdem_top_assertions i_chk (.clock, .rst_n, .power_cycle, .ctrl_reset,
   .param_wr_valid, .param_wr, .cycle_strobe, .alarm_clear, .pos_cmd_valid, .param_wr_error,
   .deviation_check_select, .position_error_limit, .servo_on_status, .ready,
   .pos_cmd_accept, .pos_cmd_reject, .alarm_code, .alarm_active, .motor_stop);
